// file: uart_fifo_test_status_pkg.sv
// Register map, field positions and reset values of the UART FIFO test and status block.
package uart_fifo_test_status_pkg;

    localparam int          ADDR_W             = 12;
    localparam int          DATA_W             = 32;

    localparam logic [11:0] OFF_RX_BUFFER      = 12'h000;
    localparam logic [11:0] OFF_FIFO_CONTROL   = 12'h008;
    localparam logic [11:0] OFF_INT_STATUS     = 12'h00c;
    localparam logic [11:0] OFF_INT_MASK       = 12'h010;
    localparam logic [11:0] OFF_ALIAS_FIRST    = 12'h030;
    localparam logic [11:0] OFF_ALIAS_LAST     = 12'h06c;
    localparam logic [11:0] OFF_TEST_ACCESS    = 12'h070;
    localparam logic [11:0] OFF_TX_PEEK        = 12'h074;
    localparam logic [11:0] OFF_RX_INJECT      = 12'h078;
    localparam logic [11:0] OFF_STATE_FLAGS    = 12'h07c;
    localparam logic [11:0] OFF_TX_FILL        = 12'h080;
    localparam logic [11:0] OFF_RX_FILL        = 12'h084;
    localparam logic [11:0] OFF_SOFT_RESET     = 12'h088;

    localparam int          BYTE_MSB           = 7;
    localparam int          INJ_PARITY_BIT     = 8;
    localparam int          INJ_FRAMING_BIT    = 9;
    localparam int          RX_ENTRY_W         = 10;

    localparam int          FLAG_BUSY          = 0;
    localparam int          FLAG_TX_NOT_FULL   = 1;
    localparam int          FLAG_TX_EMPTY      = 2;
    localparam int          FLAG_RX_NOT_EMPTY  = 3;
    localparam int          FLAG_RX_FULL       = 4;

    localparam int          SRR_UART_RESET     = 0;
    localparam int          SRR_RX_FLUSH       = 1;
    localparam int          SRR_TX_FLUSH       = 2;

    localparam int          TEST_ENABLE_BIT    = 0;
    localparam int          FIFO_ENABLE_BIT    = 0;

    localparam int          INT_W              = 4;
    localparam int          INT_RX_DATA        = 0;
    localparam int          INT_TX_EMPTY       = 1;
    localparam int          INT_RX_OVERRUN     = 2;
    localparam int          INT_TX_OVERRUN     = 3;

    localparam logic        TEST_ENABLE_RESET  = 1'b0;
    localparam logic        FIFO_ENABLE_RESET  = 1'b1;
    localparam logic [3:0]  INT_MASK_RESET     = 4'h0;

endpackage : uart_fifo_test_status_pkg

// file: uart_fifo_test_status.sv
// UART transmit/receive queues with test access, state flags and fill counts behind APB.

module sync_queue #(
    parameter int W  = 8,
    parameter int AW = 4
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    input  wire logic          flush,
    input  wire logic          cap_one,
    input  wire logic          push,
    input  wire logic [W-1:0]  push_data,
    input  wire logic          pop,
    output logic      [W-1:0]  head,
    output logic      [AW:0]   count,
    output logic               full,
    output logic               empty
);
    localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
    localparam logic [AW:0] ONE   = {{AW{1'b0}}, 1'b1};

    logic [W-1:0]  mem [2**AW];
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] wr_ptr;
    logic          do_push;
    logic          do_pop;

    // With the queues switched off the store behaves as a single holding register.
    assign full    = count >= (cap_one ? ONE : DEPTH);
    assign empty   = count == '0;
    assign head    = mem[rd_ptr];
    assign do_push = push && !full;
    assign do_pop  = pop && !empty;

    always_ff @(posedge clk) begin
        if (ce && do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count  <= '0;
        end else if (ce) begin
            if (flush) begin
                rd_ptr <= '0;
                wr_ptr <= '0;
                count  <= '0;
            end else begin
                if (do_push) begin
                    wr_ptr <= wr_ptr + 1'b1;
                end
                if (do_pop) begin
                    rd_ptr <= rd_ptr + 1'b1;
                end
                if (do_push && !do_pop) begin
                    count <= count + ONE;
                end else if (do_pop && !do_push) begin
                    count <= count - ONE;
                end
            end
        end
    end
endmodule : sync_queue

module uart_fifo_test_status
    import uart_fifo_test_status_pkg::*;
#(
    parameter int FIFO_ADDR_WIDTH = 4,
    parameter bit FIFO_ACCESS     = 1'b1,
    parameter bit FIFO_STAT       = 1'b1
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [7:0]        tx_data,
    output logic                   tx_valid,
    input  wire logic              tx_ready,
    input  wire logic [7:0]        rx_data,
    input  wire logic              rx_parity_error,
    input  wire logic              rx_framing_error,
    input  wire logic              rx_valid,
    input  wire logic              line_busy,
    output logic                   irq
);
    localparam int FILL_W = FIFO_ADDR_WIDTH + 1;

    // The fill counts and queue pointers serve address widths of 1 to 8 only.
    if (FIFO_ADDR_WIDTH < 1 || FIFO_ADDR_WIDTH > 8) begin : g_bad_width
        $error("FIFO_ADDR_WIDTH must lie between 1 and 8");
    end

    logic                  soft_reset;
    logic                  uart_rst_n;
    logic                  test_enable;
    logic                  fifo_enable;
    logic [INT_W-1:0]      int_status;
    logic [INT_W-1:0]      int_mask;
    logic                  tx_empty_seen;

    logic                  setup;
    logic                  access_done;
    logic                  wr_done;
    logic                  rd_done;
    logic                  alias_hit;
    logic                  mapped;
    logic [DATA_W-1:0]     read_value;

    logic [7:0]            tx_head;
    logic [FILL_W-1:0]     tx_count;
    logic                  tx_full;
    logic                  tx_empty;
    logic                  tx_push;
    logic                  tx_drain;
    logic                  tx_peek_pop;
    logic                  tx_flush;

    logic [RX_ENTRY_W-1:0] rx_head;
    logic [RX_ENTRY_W-1:0] rx_entry;
    logic [FILL_W-1:0]     rx_count;
    logic                  rx_full;
    logic                  rx_empty;
    logic                  rx_inject;
    logic                  rx_push;
    logic                  rx_pop;
    logic                  rx_flush;
    logic [INT_W-1:0]      events;
    logic [INT_W-1:0]      next_int_status;
    logic [4:0]            state_flags;

    assign setup       = psel && !penable;
    assign access_done = ce && psel && penable && pready;
    assign wr_done     = access_done && pwrite;
    assign rd_done     = access_done && !pwrite;

    assign alias_hit = paddr >= OFF_ALIAS_FIRST && paddr <= OFF_ALIAS_LAST && paddr[1:0] == 2'b00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_reset <= 1'b0;
        end else if (ce) begin
            soft_reset <= wr_done && paddr == OFF_SOFT_RESET && pwdata[SRR_UART_RESET];
        end
    end

    // The pulse asserts the UART reset at once and its removal lands on a clock edge.
    assign uart_rst_n = presetn && !soft_reset;

    assign tx_flush = wr_done && paddr == OFF_SOFT_RESET && pwdata[SRR_TX_FLUSH] && fifo_enable;
    assign rx_flush = wr_done && paddr == OFF_SOFT_RESET && pwdata[SRR_RX_FLUSH] && fifo_enable;

    always_ff @(posedge pclk or negedge uart_rst_n) begin
        if (!uart_rst_n) begin
            test_enable <= TEST_ENABLE_RESET;
            fifo_enable <= FIFO_ENABLE_RESET;
            int_mask    <= INT_MASK_RESET;
        end else if (ce && wr_done) begin
            if (paddr == OFF_TEST_ACCESS && FIFO_ACCESS) begin
                test_enable <= pwdata[TEST_ENABLE_BIT];
            end
            if (paddr == OFF_FIFO_CONTROL) begin
                fifo_enable <= pwdata[FIFO_ENABLE_BIT];
            end
            if (paddr == OFF_INT_MASK) begin
                int_mask <= pwdata[INT_W-1:0];
            end
        end
    end

    assign tx_push = wr_done && alias_hit;

    assign tx_peek_pop = rd_done && paddr == OFF_TX_PEEK && test_enable && FIFO_ACCESS;

    // The transmitter is held off in test mode so that the peek sees an undisturbed head.
    assign tx_drain = (!tx_valid || tx_ready) && !test_enable && !tx_empty;

    sync_queue #(
        .W  (8),
        .AW (FIFO_ADDR_WIDTH)
    ) tx_queue (
        .clk       (pclk),
        .rst_n     (uart_rst_n),
        .ce        (ce),
        .flush     (tx_flush),
        .cap_one   (!fifo_enable),
        .push      (tx_push),
        .push_data (pwdata[BYTE_MSB:0]),
        .pop       (tx_drain || tx_peek_pop),
        .head      (tx_head),
        .count     (tx_count),
        .full      (tx_full),
        .empty     (tx_empty)
    );

    always_ff @(posedge pclk or negedge uart_rst_n) begin
        if (!uart_rst_n) begin
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
        end else if (ce && (!tx_valid || tx_ready)) begin
            tx_valid <= tx_drain;
            if (tx_drain) begin
                tx_data <= tx_head;
            end
        end
    end

    assign rx_inject = wr_done && paddr == OFF_RX_INJECT && test_enable && FIFO_ACCESS;
    assign rx_push   = rx_inject || (rx_valid && !test_enable);
    assign rx_pop    = rd_done && paddr == OFF_RX_BUFFER;

    always_comb begin
        if (rx_inject) begin
            rx_entry[INJ_FRAMING_BIT] = pwdata[INJ_FRAMING_BIT];
            rx_entry[INJ_PARITY_BIT]  = pwdata[INJ_PARITY_BIT];
            rx_entry[BYTE_MSB:0]      = pwdata[BYTE_MSB:0];
        end else begin
            rx_entry = {rx_framing_error, rx_parity_error, rx_data};
        end
    end

    sync_queue #(
        .W  (RX_ENTRY_W),
        .AW (FIFO_ADDR_WIDTH)
    ) rx_queue (
        .clk       (pclk),
        .rst_n     (uart_rst_n),
        .ce        (ce),
        .flush     (rx_flush),
        .cap_one   (!fifo_enable),
        .push      (rx_push),
        .push_data (rx_entry),
        .pop       (rx_pop),
        .head      (rx_head),
        .count     (rx_count),
        .full      (rx_full),
        .empty     (rx_empty)
    );

    // Interrupt events; a new event wins over a write-one clear in the same cycle.
    always_comb begin
        events                 = '0;
        events[INT_RX_DATA]    = rx_push && !rx_full;
        events[INT_RX_OVERRUN] = rx_push && rx_full;
        events[INT_TX_OVERRUN] = tx_push && tx_full;
        events[INT_TX_EMPTY]   = tx_empty && !tx_empty_seen;
        next_int_status        = int_status;
        if (wr_done && paddr == OFF_INT_STATUS) begin
            next_int_status = int_status & ~pwdata[INT_W-1:0];
        end
        next_int_status = next_int_status | events;
    end

    always_ff @(posedge pclk or negedge uart_rst_n) begin
        if (!uart_rst_n) begin
            int_status    <= '0;
            tx_empty_seen <= 1'b1;
            irq           <= 1'b0;
        end else if (ce) begin
            int_status    <= next_int_status;
            tx_empty_seen <= tx_empty;
            irq           <= |(next_int_status & int_mask);
        end
    end

    always_comb begin
        state_flags                    = '0;
        if (FIFO_STAT) begin
            state_flags[FLAG_RX_FULL]      = rx_full;
            state_flags[FLAG_RX_NOT_EMPTY] = !rx_empty;
            state_flags[FLAG_TX_EMPTY]     = tx_empty;
            state_flags[FLAG_TX_NOT_FULL]  = !tx_full;
        end
        state_flags[FLAG_BUSY] = line_busy || tx_valid;
    end

    always_comb begin
        read_value = '0;
        mapped     = 1'b1;
        if (alias_hit) begin
            mapped = 1'b1;
        end else begin
            unique case (paddr)
                OFF_RX_BUFFER:    read_value[RX_ENTRY_W-1:0] = rx_head;
                OFF_FIFO_CONTROL: read_value[FIFO_ENABLE_BIT] = fifo_enable;
                OFF_INT_STATUS:   read_value[INT_W-1:0] = int_status;
                OFF_INT_MASK:     read_value[INT_W-1:0] = int_mask;
                OFF_TEST_ACCESS:  read_value[TEST_ENABLE_BIT] = test_enable;
                OFF_TX_PEEK: begin
                    if (test_enable && FIFO_ACCESS) begin
                        read_value[BYTE_MSB:0] = tx_head;
                    end
                end
                OFF_RX_INJECT:    read_value = '0;
                OFF_STATE_FLAGS:  read_value[4:0] = state_flags;
                OFF_TX_FILL: begin
                    if (FIFO_STAT) begin
                        read_value[FILL_W-1:0] = tx_count;
                    end
                end
                OFF_RX_FILL: begin
                    if (FIFO_STAT) begin
                        read_value[FILL_W-1:0] = rx_count;
                    end
                end
                OFF_SOFT_RESET:   read_value = '0;
                default:          mapped = 1'b0;
            endcase
        end
    end

    // A transfer whose setup cycle has ce high completes in its first access cycle; the answer is captured at setup.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= setup;
            if (setup) begin
                prdata  <= pwrite ? '0 : read_value;
                pslverr <= !mapped;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

endmodule : uart_fifo_test_status

// file: uart_fifo_test_status_monitor.sv
// Concurrent checks on the ports of the UART FIFO test and status block.
module uart_fifo_test_status_monitor
    import uart_fifo_test_status_pkg::*;
#(
    parameter int FIFO_ADDR_WIDTH = 4
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              ce,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [7:0]        tx_data,
    input wire logic              tx_valid,
    input wire logic              tx_ready,
    input wire logic              line_busy
);
    localparam logic [4:0] DEPTH = 5'(1 << FIFO_ADDR_WIDTH);
    logic busy_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= line_busy | tx_valid;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence rd_setup(logic [11:0] a);
        psel && !penable && !pwrite && ce && paddr == a;
    endsequence
    sequence rd_done(logic [11:0] a);
        pready && !pwrite && paddr == a;
    endsequence

    busy_flag_a: assert property (
        rd_setup(OFF_STATE_FLAGS) |=> prdata[FLAG_BUSY] == busy_q) else $error("busy flag");
    flags_reserved_a: assert property (
        rd_done(OFF_STATE_FLAGS) |-> prdata[31:5] == 27'h0) else $error("flags reserved");
    flag_order_a: assert property (
        rd_done(OFF_STATE_FLAGS) |-> !(prdata[FLAG_TX_EMPTY] && !prdata[FLAG_TX_NOT_FULL])
        && !(prdata[FLAG_RX_FULL] && !prdata[FLAG_RX_NOT_EMPTY])) else $error("flag order");
    tx_fill_a: assert property (
        rd_done(OFF_TX_FILL) |-> prdata[31:5] == 27'h0 && prdata[4:0] <= DEPTH)
        else $error("tx fill");
    rx_fill_a: assert property (
        rd_done(OFF_RX_FILL) |-> prdata[31:5] == 27'h0 && prdata[4:0] <= DEPTH)
        else $error("rx fill");
    test_bit_a: assert property (
        rd_done(OFF_TEST_ACCESS) |-> prdata[31:1] == 31'h0) else $error("test bit");
    peek_width_a: assert property (
        rd_done(OFF_TX_PEEK) |-> prdata[31:8] == 24'h0) else $error("peek width");
    tx_hold_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("tx hold");
    answer_once_a: assert property (
        psel && !penable && ce |=> pready ##1 !pready) else $error("answer timing");
endmodule : uart_fifo_test_status_monitor

// file: serial_peer_model.sv
// Far-side serial peer: takes transmit bytes with stalls and sends receive entries.
module serial_peer_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic [7:0]      rx_data,
    output logic            rx_parity_error,
    output logic            rx_framing_error,
    output logic            rx_valid,
    output logic            line_busy,
    input  wire logic       kick,
    output int              taken,
    output logic [7:0]      last_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] gap;

    // One byte is taken promptly, then the line stays busy for three cycles.
    assign tx_ready  = (gap == 2'h0);
    assign line_busy = (gap != 2'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap       <= 2'h0;
            taken     <= 0;
            last_byte <= 8'h00;
        end else if (gap != 2'h0) begin
            gap <= gap + 2'h1;
        end else if (tx_valid) begin
            gap       <= 2'h1;
            taken     <= taken + 1;
            last_byte <= tx_data;
        end
    end

    // Between entries the lines toggle so stale values never pass for data.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_valid         <= 1'b0;
            rx_data          <= 8'h00;
            rx_parity_error  <= 1'b0;
            rx_framing_error <= 1'b0;
        end else begin
            rx_valid         <= kick;
            rx_data          <= kick ? 8'h5a : ~rx_data;
            rx_parity_error  <= kick ? 1'b0 : ~rx_parity_error;
            rx_framing_error <= kick ? 1'b1 : ~rx_framing_error;
        end
    end
endmodule : serial_peer_model

// file: tb_top.sv
// Self-checking bench for the UART FIFO test and status block.
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch %s exp %h got %h", what, exp, got); end end

module tb_top
    import uart_fifo_test_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              pclk    = 1'b0;
    logic              presetn = 1'b0;
    logic              ce      = 1'b1;
    logic [ADDR_W-1:0] paddr   = '0;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [DATA_W-1:0] pwdata  = '0;
    logic              kick    = 1'b0;
    logic [DATA_W-1:0] prdata, rdata;
    logic              pready, pslverr, rerr, tx_valid, tx_ready, irq;
    logic              rx_pe, rx_fe, rx_valid, line_busy;
    logic [7:0]        tx_data, rx_data, last_byte;
    int                errors = 0;
    int                checks = 0;
    int                cycles = 0;
    int                taken;

    always #10 pclk = ~pclk;

    uart_fifo_test_status #(.FIFO_ADDR_WIDTH(4)) u_uart_fifo_test_status (
        .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_parity_error(rx_pe),
        .rx_framing_error(rx_fe), .rx_valid(rx_valid), .line_busy(line_busy), .irq(irq));

    serial_peer_model u_serial_peer_model (
        .pclk(pclk), .presetn(presetn), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_parity_error(rx_pe),
        .rx_framing_error(rx_fe), .rx_valid(rx_valid), .line_busy(line_busy),
        .kick(kick), .taken(taken), .last_byte(last_byte));

    task automatic summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for the answer.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata   = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        `CHK(what, exp, rdata)
    endtask : chk

    task automatic pulse;
        @(posedge pclk);
        kick <= 1'b1;
        @(posedge pclk);
        kick <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : pulse

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk("flags", OFF_STATE_FLAGS, 32'h6);
        chk("tx fill", OFF_TX_FILL, 32'h0);
        chk("rx fill", OFF_RX_FILL, 32'h0);
        chk("test", OFF_TEST_ACCESS, 32'h0);
        xfer(1'b0, 12'h0f0, 32'h0);
        `CHK("slverr", 1'b1, rerr)
        $display("test reset done");
        xfer(1'b1, OFF_TEST_ACCESS, 32'hffffffff);
        chk("test", OFF_TEST_ACCESS, 32'h1);
        for (int i = 0; i < 16; i++) begin
            xfer(1'b1, OFF_ALIAS_FIRST + 12'(4 * i), 32'hffffff10 + 32'(i));
            xfer(1'b1, OFF_RX_INJECT, {22'h0, 2'(i + 1), 8'h80 + 8'(i)});
        end
        xfer(1'b1, OFF_RX_INJECT, 32'h0);
        chk("tx fill", OFF_TX_FILL, 32'h10);
        chk("rx fill", OFF_RX_FILL, 32'h10);
        chk("flags", OFF_STATE_FLAGS, 32'h18);
        chk("peek", OFF_TX_PEEK, 32'h10);
        chk("flags", OFF_STATE_FLAGS, 32'h1a);
        chk("tx fill", OFF_TX_FILL, 32'hf);
        chk("rx head", OFF_RX_BUFFER, 32'h180);
        chk("rx next", OFF_RX_BUFFER, 32'h281);
        $display("test access done");
        xfer(1'b1, OFF_TEST_ACCESS, 32'h0);
        xfer(1'b0, OFF_STATE_FLAGS, 32'h0);
        `CHK("busy", 1'b1, rdata[FLAG_BUSY])
        for (int n = 0; n < 500 && !(taken == 15 && !tx_valid && !line_busy); n++) begin
            @(posedge pclk);
        end
        `CHK("taken", 32'd15, 32'(taken))
        `CHK("last", 8'h1f, last_byte)
        chk("flags", OFF_STATE_FLAGS, 32'h0e);
        chk("tx fill", OFF_TX_FILL, 32'h0);
        $display("test drain done");
        xfer(1'b0, OFF_INT_STATUS, 32'h0);
        `CHK("int", 2'b11, rdata[2:1])
        xfer(1'b1, OFF_INT_MASK, 32'h2);
        repeat (2) @(posedge pclk);
        `CHK("irq", 1'b1, irq)
        xfer(1'b1, OFF_INT_STATUS, 32'h2);
        repeat (2) @(posedge pclk);
        `CHK("irq", 1'b0, irq)
        pulse();
        chk("rx fill", OFF_RX_FILL, 32'hf);
        $display("test interrupt done");
        chk("peek off", OFF_TX_PEEK, 32'h0);
        xfer(1'b1, OFF_RX_INJECT, 32'h3ff);
        chk("rx fill", OFF_RX_FILL, 32'hf);
        xfer(1'b1, OFF_SOFT_RESET, 32'h6);
        chk("rx fill", OFF_RX_FILL, 32'h0);
        // With the clock enable low a received entry must leave no trace.
        ce <= 1'b0;
        pulse();
        ce <= 1'b1;
        chk("rx fill", OFF_RX_FILL, 32'h0);
        pulse();
        chk("rx link", OFF_RX_BUFFER, 32'h25a);
        $display("test flush and freeze done");
        xfer(1'b1, OFF_FIFO_CONTROL, 32'h0);
        xfer(1'b1, OFF_TEST_ACCESS, 32'h1);
        xfer(1'b1, OFF_ALIAS_FIRST, 32'h21);
        xfer(1'b1, OFF_ALIAS_LAST, 32'h22);
        xfer(1'b1, OFF_RX_INJECT, 32'h3c5);
        chk("flags", OFF_STATE_FLAGS, 32'h18);
        chk("peek", OFF_TX_PEEK, 32'h21);
        xfer(1'b0, OFF_INT_STATUS, 32'h0);
        `CHK("tx overrun", 1'b1, rdata[INT_TX_OVERRUN])
        $display("test single entry done");
        xfer(1'b1, OFF_SOFT_RESET, 32'h1);
        chk("rx fill", OFF_RX_FILL, 32'h0);
        chk("mask", OFF_INT_MASK, 32'h0);
        chk("fifo on", OFF_FIFO_CONTROL, 32'h1);
        chk("test", OFF_TEST_ACCESS, 32'h0);
        `CHK("irq", 1'b0, irq)
        $display("test soft reset done");
        summarize();
    end
endmodule : tb_top

bind uart_fifo_test_status uart_fifo_test_status_monitor #(
    .FIFO_ADDR_WIDTH(FIFO_ADDR_WIDTH)) u_mon (
    .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .line_busy(line_busy));
